// ===== hw/sdr_pkg.sv
// Shared constants of the DRAM command timing core.
// Assumes a single 100 MHz clock; all figures become cycle counts here.
package sdr_pkg;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int ROW_ACTIVE_MIN_PS = 40000;
	localparam int PRECHARGE_PS = 15000;
	localparam int READ_TO_PRECH_PS = 7500;
	localparam int CKE_REG_EDGES = 3;
	localparam int ROW_ACTIVE_CYC = (ROW_ACTIVE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PRECHARGE_CYC = (PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_TO_PRECH_CYC = (READ_TO_PRECH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Termination delays in half clocks: on 2.0, off 2.5 rounded up
	localparam int TERM_ON_HALF = 4;
	localparam int TERM_OFF_HALF = 5;
	localparam int TERM_ON_CYC = (TERM_ON_HALF + 1) / 2;
	localparam int TERM_OFF_CYC = (TERM_OFF_HALF + 1) / 2;
	localparam int BANKS = 4;
	localparam int DQ_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int REF_CNT_W = 13;
	// Mode register fields
	localparam int MR_WR_LSB = 9;
	localparam int MR_WR_MSB = 11;
	localparam int MR_BL_LSB = 0;
	localparam int MR_BL_MSB = 2;
	localparam logic [2:0] MR_BL8 = 3'h3;
	localparam logic [2:0] MR_WR_RESET = 3'h1;
	localparam logic [2:0] MR_BL_RESET = 3'h2;
	localparam int AP_BIT = 10;
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_ACT = 3'b001,
		CMD_READ = 3'b010,
		CMD_WRITE = 3'b011,
		CMD_PRE = 3'b100,
		CMD_REF = 3'b101,
		CMD_MRS = 3'b110
	} sdr_cmd_t;
	typedef enum logic [1:0] {
		WID_X4 = 2'b00,
		WID_X8 = 2'b01,
		WID_X16 = 2'b10
	} sdr_width_t;
endpackage

// ===== hw/sdr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module sdr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ===== hw/sdr_bank_timer.sv
// One bank's row-active lockout and deferred internal precharge.
// Assumes commands arrive already synchronised and decoded.
module sdr_bank_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Commands for this bank
	input wire logic activate,
	input wire logic precharge,
	input wire logic ap_request,
	input wire logic [4:0] ap_delay,
	// State
	output logic bank_open,
	output logic ras_met,
	output logic ap_pending,
	output logic int_precharge
);
	localparam logic [2:0] RAS_CYC = 3'(sdr_pkg::ROW_ACTIVE_CYC);
	logic [2:0] ras_cnt;
	logic [4:0] dly;
	// Internal precharge waits for both the burst delay and the lockout
	wire fire = ap_pending && (dly == 5'h0) && ras_met;

	assign ras_met = ras_cnt == RAS_CYC;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ras_cnt <= 3'h0;
			dly <= 5'h0;
			bank_open <= 1'b0;
			ap_pending <= 1'b0;
			int_precharge <= 1'b0;
		end else begin
			int_precharge <= fire;
			if (activate) begin
				ras_cnt <= 3'h1;
				bank_open <= 1'b1;
			end else if (bank_open && !ras_met) begin
				ras_cnt <= ras_cnt + 3'h1;
			end
			if (ap_request) begin
				ap_pending <= 1'b1;
				dly <= ap_delay;
			end else if (fire || precharge) begin
				ap_pending <= 1'b0;
			end else if (ap_pending && dly != 5'h0) begin
				dly <= dly - 5'h1;
			end
			if (fire || precharge) begin
				bank_open <= 1'b0;
			end
		end
	end
endmodule

// ===== hw/sdr_core.sv
// Command timing core of a four-bank DDR DRAM, device side.
// Assumes command, address, clock-enable, termination and data pins arrive
// asynchronously and are synchronised here; array side runs on sys_clk.
//
// Operation
// - Internal precharge waits for row active minimum
// - Read-to-precharge counted from last prefetch
// - Write recovery clocks from mode bits 9-11
// - Refreshes may burst, no upper bound
// - Termination off delay 2.5 clocks nominal
// - Termination begins at minimum, full at maximum
// - Each strobe qualifies its own lane group
module sdr_core (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Command pins
	input wire logic [2:0] cmd_pin,
	input wire logic [1:0] bank_pin,
	input wire logic [12:0] addr_pin,
	input wire logic clock_enable_pin,
	input wire logic on_die_termination_pin,
	// Configuration
	input wire logic [1:0] width_mode,
	input wire logic [2:0] additive_latency,
	// Write data pins
	input wire logic [15:0] dq_pin,
	input wire logic lower_byte_strobe,
	input wire logic upper_byte_strobe,
	// Array side write stream
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [15:0] wr_data,
	output logic [15:0] wr_lane_mask,
	output logic wr_overflow,
	// Status
	output logic cke_registered,
	output logic [3:0] bank_open,
	output logic [3:0] int_precharge,
	output logic [2:0] write_recovery_clocks,
	output logic [2:0] burst_code,
	output logic [12:0] refresh_count,
	output logic term_starting,
	output logic term_full
);
	// Two-flop synchronisers for every pin input
	localparam int PIN_W = 3 + 2 + 13 + 1 + 1 + 16 + 1 + 1;
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	always_ff @(posedge sys_clk) begin
		pin_s1 <= {cmd_pin, bank_pin, addr_pin, clock_enable_pin, on_die_termination_pin,
			dq_pin, lower_byte_strobe, upper_byte_strobe};
		pin_s2 <= pin_s1;
	end

	wire [2:0] cmd_s = pin_s2[PIN_W-1 -: 3];
	wire [1:0] bank_s = pin_s2[PIN_W-4 -: 2];
	wire [12:0] addr_s = pin_s2[PIN_W-6 -: 13];
	wire cke_s = pin_s2[PIN_W-19];
	wire odt_s = pin_s2[PIN_W-20];
	wire [15:0] dq_s = pin_s2[PIN_W-21 -: 16];
	wire lstb_s = pin_s2[1];
	wire ustb_s = pin_s2[0];

	// Clock enable takes effect after three equal consecutive samples
	logic [1:0] cke_run;
	logic cke_last;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cke_run <= 2'h0;
			cke_last <= 1'b0;
			cke_registered <= 1'b0;
		end else begin
			cke_last <= cke_s;
			if (cke_s != cke_last) begin
				cke_run <= 2'h1;
			end else if (cke_run != 2'(sdr_pkg::CKE_REG_EDGES - 1)) begin
				cke_run <= cke_run + 2'h1;
			end else begin
				cke_registered <= cke_s;
			end
		end
	end

	// Command decode, ignored while the clock enable is registered low
	wire cmd_en = cke_registered;
	wire is_act = cmd_en && cmd_s == sdr_pkg::CMD_ACT;
	wire is_rd = cmd_en && cmd_s == sdr_pkg::CMD_READ;
	wire is_wr = cmd_en && cmd_s == sdr_pkg::CMD_WRITE;
	wire is_pre = cmd_en && cmd_s == sdr_pkg::CMD_PRE;
	wire is_ref = cmd_en && cmd_s == sdr_pkg::CMD_REF;
	wire is_mrs = cmd_en && cmd_s == sdr_pkg::CMD_MRS && bank_s == 2'h0;
	wire ap_flag = addr_s[sdr_pkg::AP_BIT];
	wire pre_all = is_pre && ap_flag;

	// Mode register: burst length and write recovery
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			write_recovery_clocks <= sdr_pkg::MR_WR_RESET;
			burst_code <= sdr_pkg::MR_BL_RESET;
		end else if (is_mrs) begin
			write_recovery_clocks <= addr_s[sdr_pkg::MR_WR_MSB:sdr_pkg::MR_WR_LSB];
			burst_code <= addr_s[sdr_pkg::MR_BL_MSB:sdr_pkg::MR_BL_LSB];
		end
	end

	// Field value n means n+1 recovery clocks
	wire [4:0] wr_clocks = {2'h0, write_recovery_clocks} + 5'h1;
	wire [4:0] half_burst = (burst_code == sdr_pkg::MR_BL8) ? 5'h4 : 5'h2;
	// Last four-bit prefetch starts two clocks before the burst's end
	wire [4:0] last_prefetch = {2'h0, additive_latency} + half_burst - 5'h2;
	wire [4:0] rd_ap_delay = last_prefetch + 5'(sdr_pkg::READ_TO_PRECH_CYC);
	wire [4:0] wr_ap_delay = half_burst + wr_clocks;
	wire [4:0] ap_delay = is_rd ? rd_ap_delay : wr_ap_delay;

	logic [3:0] ras_met;
	logic [3:0] ap_pending;
	genvar b;
	generate
		for (b = 0; b < sdr_pkg::BANKS; b++) begin : g_bank
			wire sel = bank_s == 2'(b);
			sdr_bank_timer u_timer (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.activate(is_act && sel),
				.precharge((is_pre && sel) || pre_all),
				.ap_request((is_rd || is_wr) && ap_flag && sel),
				.ap_delay(ap_delay),
				.bank_open(bank_open[b]),
				.ras_met(ras_met[b]),
				.ap_pending(ap_pending[b]),
				.int_precharge(int_precharge[b])
			);
		end
	endgenerate

	// Refresh commands counted with no limit on back-to-back bursts
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			refresh_count <= 13'h0;
		end else if (is_ref) begin
			refresh_count <= refresh_count + 13'h1;
		end
	end

	// Termination delay lines, timed from the sampled request
	localparam int TL = sdr_pkg::TERM_OFF_CYC;
	logic [TL-1:0] odt_line;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			odt_line <= '0;
			term_starting <= 1'b0;
			term_full <= 1'b0;
		end else begin
			odt_line <= {odt_line[TL-2:0], odt_s};
			// Turn-on: begin at the on delay, fully on one clock later
			if (odt_line[sdr_pkg::TERM_ON_CYC-1] && !term_starting) begin
				term_starting <= 1'b1;
			end else if (!odt_line[sdr_pkg::TERM_OFF_CYC-1] && !odt_line[sdr_pkg::TERM_ON_CYC-1]) begin
				term_starting <= 1'b0;
			end
			term_full <= term_starting && odt_line[sdr_pkg::TERM_ON_CYC-1];
		end
	end

	// Lane groups qualified by their own strobe
	wire [15:0] mask_x4 = {12'h000, {4{lstb_s}}};
	wire [15:0] mask_x8 = {8'h00, {8{lstb_s}}};
	wire [15:0] mask_x16 = {{8{ustb_s}}, {8{lstb_s}}};
	wire [15:0] lane_mask = (width_mode == sdr_pkg::WID_X4) ? mask_x4 :
		(width_mode == sdr_pkg::WID_X8) ? mask_x8 : mask_x16;
	wire beat_valid = lane_mask != 16'h0;
	wire fifo_in_ready;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_overflow <= 1'b0;
		end else if (beat_valid && !fifo_in_ready) begin
			wr_overflow <= 1'b1;
		end
	end

	sdr_fifo #(
		.WIDTH(32),
		.DEPTH(sdr_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_valid(beat_valid),
		.in_ready(fifo_in_ready),
		.in_data({lane_mask, dq_s & lane_mask}),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data({wr_lane_mask, wr_data})
	);

	// Checks
	property p_lockout;
		@(posedge sys_clk) disable iff (!reset_n)
		int_precharge[1] |-> $past(ras_met[1]);
	endproperty
	a_lockout: assert property (p_lockout) else $error("precharge before lockout");

	property p_ap_fires;
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(ap_pending[1]) ##0 !is_pre && !is_act
			|-> ##[1:24] int_precharge[1];
	endproperty
	a_ap_fires: assert property (p_ap_fires) else $error("pending precharge lost");

	property p_rd_delay;
		@(posedge sys_clk) disable iff (!reset_n)
		(is_rd && ap_flag && bank_s == 2'h1) ##1 !is_pre [*2]
			|-> !int_precharge[1];
	endproperty
	a_rd_delay: assert property (p_rd_delay) else $error("read precharge too early");

	property p_mode_wr;
		@(posedge sys_clk) disable iff (!reset_n)
		is_mrs |=> write_recovery_clocks == $past(addr_s[11:9]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("recovery field not taken");

	property p_refresh_burst;
		@(posedge sys_clk) disable iff (!reset_n)
		is_ref ##1 is_ref |=> refresh_count == $past(refresh_count, 2) + 13'h2;
	endproperty
	a_refresh_burst: assert property (p_refresh_burst) else $error("burst refresh dropped");

	sequence s_odt_on;
		!odt_s ##1 odt_s [*3];
	endsequence
	property p_term_on;
		@(posedge sys_clk) disable iff (!reset_n)
		s_odt_on |=> term_starting ##1 term_full;
	endproperty
	a_term_on: assert property (p_term_on) else $error("termination on timing");

	property p_term_off;
		@(posedge sys_clk) disable iff (!reset_n)
		$fell(odt_s) ##1 !odt_s [*3] |=> !term_starting && !term_full;
	endproperty
	a_term_off: assert property (p_term_off) else $error("termination off timing");

	property p_lanes;
		@(posedge sys_clk) disable iff (!reset_n)
		width_mode != sdr_pkg::WID_X16 |-> lane_mask[15:8] == 8'h00;
	endproperty
	a_lanes: assert property (p_lanes) else $error("upper lanes used when narrow");

	property p_cke;
		@(posedge sys_clk) disable iff (!reset_n)
		$changed(cke_registered) |->
			$past(cke_s) == $past(cke_s, 2) && $past(cke_s, 2) == $past(cke_s, 3);
	endproperty
	a_cke: assert property (p_cke) else $error("clock enable registered early");

	// Commands are ignored until the clock enable is registered high
	property p_cke_gate;
		@(posedge sys_clk) disable iff (!reset_n)
		!cke_registered |=> (bank_open & ~$past(bank_open)) == 4'h0;
	endproperty
	a_cke_gate: assert property (p_cke_gate) else $error("command taken while disabled");

	property p_int_pulse;
		@(posedge sys_clk) disable iff (!reset_n)
		int_precharge[1] |=> !int_precharge[1];
	endproperty
	a_int_pulse: assert property (p_int_pulse) else $error("precharge pulse too long");

	property p_bank_close;
		@(posedge sys_clk) disable iff (!reset_n)
		int_precharge[1] |-> !bank_open[1];
	endproperty
	a_bank_close: assert property (p_bank_close) else $error("bank left open");

	property p_lane_x4;
		@(posedge sys_clk) disable iff (!reset_n)
		width_mode == sdr_pkg::WID_X4 |-> lane_mask[15:4] == 12'h000;
	endproperty
	a_lane_x4: assert property (p_lane_x4) else $error("lanes above nibble used");

	property p_refresh_one;
		@(posedge sys_clk) disable iff (!reset_n)
		is_ref |=> refresh_count == $past(refresh_count) + 13'h1;
	endproperty
	a_refresh_one: assert property (p_refresh_one) else $error("refresh not counted");

	property p_term_order;
		@(posedge sys_clk) disable iff (!reset_n)
		term_full |-> term_starting;
	endproperty
	a_term_order: assert property (p_term_order) else $error("full before start");
endmodule

// ===== verif/sdr_ctrl_model.sv
// Controller-side model: drives command, enable, termination and write pins.
// Assumes the bench calls its tasks from one process, one at a time.
module sdr_ctrl_model (
	// Clock
	input wire logic sys_clk,
	// Command pins
	output logic [2:0] cmd_pin,
	output logic [1:0] bank_pin,
	output logic [12:0] addr_pin,
	output logic clock_enable_pin,
	output logic on_die_termination_pin,
	// Write data pins
	output logic [15:0] dq_pin,
	output logic lower_byte_strobe,
	output logic upper_byte_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmd_pin = 3'h0;
		bank_pin = 2'h0;
		addr_pin = 13'h0;
		clock_enable_pin = 1'b0;
		on_die_termination_pin = 1'b0;
		dq_pin = 16'h0;
		lower_byte_strobe = 1'b0;
		upper_byte_strobe = 1'b0;
	end
	// Released bank and address lines carry the inverse of their last value; the command returns to NOP
	task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
		input int n);
		@(posedge sys_clk);
		#1;
		cmd_pin = c;
		bank_pin = b;
		addr_pin = a;
		repeat (n) @(posedge sys_clk);
		#1;
		cmd_pin = 3'h0;
		bank_pin = ~b;
		addr_pin = ~a;
		if (c == 3'h4) begin
			repeat (sdr_pkg::PRECHARGE_CYC) @(posedge sys_clk);
			#1;
		end
	endtask
	task automatic pins(input logic cke, input logic on_die_termination);
		@(posedge sys_clk);
		#1;
		clock_enable_pin = cke;
		on_die_termination_pin = on_die_termination;
	endtask
	// Strobes stay high a full cycle before they return low
	task automatic beat(input logic lo, input logic hi, input logic [15:0] d);
		@(posedge sys_clk);
		#1;
		dq_pin = d;
		lower_byte_strobe = lo;
		upper_byte_strobe = hi;
		@(posedge sys_clk);
		#1;
		lower_byte_strobe = 1'b0;
		upper_byte_strobe = 1'b0;
		dq_pin = ~d;
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the command timing core.
// Assumes the controller model drives all pins; the bench plays the array side.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] width_mode = sdr_pkg::WID_X16;
	logic [2:0] additive_latency = 3'h0;
	logic wr_ready = 1'b0;
	logic [2:0] cmd_pin, write_recovery_clocks, burst_code;
	logic [1:0] bank_pin;
	logic [12:0] addr_pin, refresh_count;
	logic [15:0] dq_pin, wr_data, wr_lane_mask;
	logic [3:0] bank_open, int_precharge;
	logic clock_enable_pin, on_die_termination_pin, lower_byte_strobe, upper_byte_strobe;
	logic wr_valid, wr_overflow, cke_registered, term_starting, term_full;
	logic [15:0] lo_mask [3] = '{16'h000f, 16'h00ff, 16'h00ff};
	int fail_count = 0;
	int num_checks = 0;
	int n;
	always #5 sys_clk = ~sys_clk;
	sdr_ctrl_model ctl (.sys_clk(sys_clk), .cmd_pin(cmd_pin), .bank_pin(bank_pin),
		.addr_pin(addr_pin), .clock_enable_pin(clock_enable_pin),
		.on_die_termination_pin(on_die_termination_pin), .dq_pin(dq_pin),
		.lower_byte_strobe(lower_byte_strobe), .upper_byte_strobe(upper_byte_strobe));
	sdr_core uut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_pin(cmd_pin), .bank_pin(bank_pin),
		.addr_pin(addr_pin), .clock_enable_pin(clock_enable_pin),
		.on_die_termination_pin(on_die_termination_pin), .width_mode(width_mode),
		.additive_latency(additive_latency), .dq_pin(dq_pin),
		.lower_byte_strobe(lower_byte_strobe), .upper_byte_strobe(upper_byte_strobe),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.wr_lane_mask(wr_lane_mask), .wr_overflow(wr_overflow),
		.cke_registered(cke_registered), .bank_open(bank_open), .int_precharge(int_precharge),
		.write_recovery_clocks(write_recovery_clocks), .burst_code(burst_code),
		.refresh_count(refresh_count), .term_starting(term_starting), .term_full(term_full));
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict;
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic expire(input string what);
		fail_count++;
		$display("wrong value at %0t: timeout on %s", $time, what);
		give_verdict();
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	// Takes the head word of the write stream and compares it
	task automatic pop(input logic [15:0] m, input logic [15:0] d);
		for (n = 0; n < 20 && wr_valid !== 1'b1; n++) tick(1);
		if (wr_valid !== 1'b1) expire("write word");
		check(wr_lane_mask, m, "lane mask");
		check(wr_data, d, "lane data");
		wr_ready = 1'b1;
		tick(1);
		wr_ready = 1'b0;
		tick(1);
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		expire("run");
	end
	initial begin
		tick(5);
		reset_n = 1'b1;
		check(16'(write_recovery_clocks), 16'(sdr_pkg::MR_WR_RESET), "recovery after reset");
		check(16'(burst_code), 16'(sdr_pkg::MR_BL_RESET), "burst code after reset");
		check(16'({bank_open, wr_valid}), 16'h0, "open banks after reset");
		ctl.pins(1'b1, 1'b0);
		for (n = 0; n < 20 && cke_registered !== 1'b1; n++) tick(1);
		if (cke_registered !== 1'b1) expire("clock enable");
		// Read with auto precharge straight after activate
		ctl.issue(sdr_pkg::CMD_ACT, 2'h1, 13'h0, 1);
		ctl.issue(sdr_pkg::CMD_READ, 2'h1, 13'h0400, 1);
		check(16'(bank_open), 16'h2, "bank one open");
		for (int k = 0; k < 3; k++) begin
			tick(1);
			check(16'(int_precharge), 16'h0, "early precharge");
		end
		for (n = 0; n < 10 && int_precharge[1] !== 1'b1; n++) tick(1);
		if (int_precharge[1] !== 1'b1) expire("internal precharge");
		check(16'(bank_open), 16'h0, "bank closed by precharge");
		ctl.issue(sdr_pkg::CMD_ACT, 2'h2, 13'h0, 1);
		tick(2);
		check(16'(bank_open), 16'h4, "bank two open");
		ctl.issue(sdr_pkg::CMD_PRE, 2'h0, 13'h0400, 1);
		check(16'(bank_open), 16'h0, "all banks closed");
		ctl.issue(sdr_pkg::CMD_MRS, 2'h0, 13'h0803, 1);
		tick(3);
		check(16'(write_recovery_clocks), 16'h4, "recovery field");
		check(16'(burst_code), 16'(sdr_pkg::MR_BL8), "burst field");
		ctl.issue(sdr_pkg::CMD_REF, 2'h0, 13'h0, 3);
		tick(3);
		check(16'(refresh_count), 16'h3, "refresh burst");
		ctl.pins(1'b1, 1'b1);
		for (n = 0; n < 10 && term_starting !== 1'b1; n++) tick(1);
		if (term_starting !== 1'b1) expire("termination start");
		check(16'(term_full), 16'h0, "full before start");
		tick(1);
		check(16'(term_full), 16'h1, "full one later");
		ctl.pins(1'b1, 1'b0);
		tick(2);
		check(16'(term_full), 16'h1, "off delay");
		for (n = 0; n < 8 && term_starting !== 1'b0; n++) tick(1);
		check(16'({term_full, term_starting}), 16'h0, "termination off");
		for (int w = 0; w < 3; w++) begin
			width_mode = 2'(w);
			ctl.beat(1'b1, 1'b0, 16'hffff);
			pop(lo_mask[w], lo_mask[w]);
		end
		ctl.beat(1'b0, 1'b1, 16'ha5a5);
		pop(16'hff00, 16'ha500);
		check(16'(wr_overflow), 16'h0, "no overflow yet");
		for (int k = 0; k < 17; k++) ctl.beat(1'b1, 1'b1, 16'(k));
		tick(3);
		check(16'(wr_overflow), 16'h1, "overflow flag");
		for (int k = 0; k < 16; k++) pop(16'hffff, 16'(k));
		tick(1);
		check(16'(wr_valid), 16'h0, "drained");
		give_verdict();
	end
endmodule
